// >>> hw/cst_clock_select.sv
`timescale 1ns/1ns
module cst_clock_select (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire cst_pkg::cst_bus_t bus_in,
  input wire cst_pkg::cst_src_t src_in,
  input wire logic [1:0] itmr_sel_in,
  input wire logic [1:0] itmr_div_in,
  input wire logic [1:0] tcap_sel_in,
  input wire logic [1:0] clock_output_pin_sel_in,
  input wire logic sleep_in,
  input wire logic usb_packet_in,
  output logic [7:0] rdata_out,
  output logic cpu_en_out,
  output logic usb_en_out,
  output logic itmr_en_out,
  output logic tcap_en_out,
  output logic clock_output_pin_out,
  output logic [7:0] fast_trim_out,
  output logic [7:0] slow_trim_out,
  output logic lowpwr_out,
  output logic det_on_out,
  output logic [1:0] sleep_timer_out,
  output logic lock_active_out,
  output logic coarse_ok_out
);
  logic rst_s1_q;
  logic rst_n_q;
  logic [2:0] src_s1_q;
  logic [2:0] src_q;
  logic [2:0] src_prev_q;
  logic [1:0] pkt_sync_q;
  logic [7:0] cpu_usb_q;
  logic [7:0] fast_trim_q;
  logic [7:0] slow_trim_q;
  logic [7:0] lock_q;
  logic [7:0] osc0_q;
  logic [6:0] cpu_cnt_q;
  logic [1:0] itmr_cnt_q;
  logic usb_half_q;
  logic [7:0] rdata_q;
  logic cpu_en_q;
  logic usb_en_q;
  logic itmr_en_q;
  logic tcap_en_q;
  logic clock_output_pin_q;

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // oscillator and pin levels are foreign: synchronise, then detect rises
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      src_s1_q <= 3'h0;
      src_q <= 3'h0;
      src_prev_q <= 3'h0;
      pkt_sync_q <= 2'h0;
    end else begin
      // packet flag comes from the usb engine's own clock
      pkt_sync_q <= {pkt_sync_q[0], usb_packet_in};
      src_s1_q <= {src_in.fast_osc, src_in.slow_osc, src_in.ext_clk};
      src_q <= src_s1_q;
      src_prev_q <= src_q;
    end
  end

  wire [2:0] rise = src_q & ~src_prev_q;
  wire fast_tick = rise[2];
  wire slow_tick = rise[1];
  wire ext_tick = rise[0];

  // register decode: the second bank answers only with the bank flag set
  function automatic logic reg_hit(input cst_pkg::cst_bus_t bus, input logic [8:0] addr,
                                   input logic bank);
    reg_hit = bus.addr == addr && bus.extended_io_bank_flag == bank;
  endfunction

  wire hit_cpu_usb = reg_hit(bus_in, cst_pkg::ADDR_CPU_USB_CFG, 1'b0);
  wire hit_fast = reg_hit(bus_in, cst_pkg::ADDR_FAST_TRIM, 1'b0);
  wire hit_slow = reg_hit(bus_in, cst_pkg::ADDR_SLOW_TRIM, 1'b0);
  wire hit_lock = reg_hit(bus_in, cst_pkg::ADDR_LOCK_CFG, 1'b0);
  wire hit_osc0 = reg_hit(bus_in, cst_pkg::ADDR_OSC_CTRL0, 1'b1);

  wire wr_cpu_usb = bus_in.wr && hit_cpu_usb;
  wire wr_fast = bus_in.wr && hit_fast;
  wire wr_slow = bus_in.wr && hit_slow;
  wire wr_lock = bus_in.wr && hit_lock;
  wire wr_osc0 = bus_in.wr && hit_osc0;

  logic [7:0] rd_mux;
  always_comb begin
    if (hit_cpu_usb) begin
      rd_mux = cpu_usb_q;
    end else if (hit_fast) begin
      rd_mux = fast_trim_q;
    end else if (hit_slow) begin
      rd_mux = slow_trim_q;
    end else if (hit_lock) begin
      rd_mux = lock_q;
    end else if (hit_osc0) begin
      rd_mux = osc0_q;
    end else begin
      // unmapped and wrong-bank reads return zero
      rd_mux = cst_pkg::RESET_ZERO;
    end
  end

  // trim fields keep no reset: boot code loads calibration
  always_ff @(posedge clk_in) begin
    if (wr_fast) begin
      fast_trim_q <= bus_in.wdata;
    end
    if (wr_slow) begin
      slow_trim_q <= bus_in.wdata & cst_pkg::SLOW_TRIM_MASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_usb_q <= cst_pkg::RESET_ZERO;
      lock_q <= cst_pkg::RESET_ZERO;
      osc0_q <= cst_pkg::RESET_ZERO;
      rdata_q <= cst_pkg::RESET_ZERO;
    end else begin
      if (wr_cpu_usb) begin
        cpu_usb_q <= bus_in.wdata & cst_pkg::CPU_USB_CFG_MASK;
      end else if (sleep_in) begin
        cpu_usb_q[cst_pkg::CPU_SEL_BIT] <= 1'b0;
      end
      if (wr_lock) begin
        lock_q <= bus_in.wdata & cst_pkg::LOCK_CFG_MASK;
      end
      if (wr_osc0) begin
        osc0_q <= bus_in.wdata & cst_pkg::OSC_CTRL0_MASK;
      end
      if (bus_in.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // processor clock: pick source, then divide by power of two
  // glitch-free changeover: ticks stop, the old source ends its period, then the
  // new source starts on a fresh edge; the drain also ends on a new-source edge so
  // a stopped external clock cannot strand the switch, at the cost of a short gap
  typedef enum logic [1:0] {
    SW_RUN = 2'h0,
    SW_DRAIN = 2'h1,
    SW_ARM = 2'h3,
    SW_SETTLE = 2'h2
  } cst_sw_state_t;
  wire [1:0] sw_req = {cpu_usb_q[cst_pkg::USB_SEL_BIT], cpu_usb_q[cst_pkg::CPU_SEL_BIT]};
  wire [1:0] sw_tick;
  wire [1:0] sw_sel;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sw
      cst_sw_state_t state_q;
      cst_sw_state_t state_d;
      logic cur_q;
      logic cur_d;
      wire old_tick = cur_q ? ext_tick : fast_tick;
      wire new_tick = sw_req[g] ? ext_tick : fast_tick;
      always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        case (state_q)
          SW_RUN: begin
            if (sw_req[g] != cur_q) begin
              state_d = SW_DRAIN;
            end
          end
          SW_DRAIN: begin
            if (old_tick || new_tick) begin
              state_d = SW_ARM;
            end
          end
          SW_ARM: begin
            if (new_tick) begin
              state_d = SW_SETTLE;
              cur_d = sw_req[g];
            end
          end
          SW_SETTLE: begin
            state_d = SW_RUN;
          end
          default: begin
            state_d = SW_RUN;
          end
        endcase
      end
      always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
          state_q <= SW_RUN;
          cur_q <= 1'b0;
        end else begin
          state_q <= state_d;
          cur_q <= cur_d;
        end
      end
      assign sw_tick[g] = state_q == SW_RUN && old_tick;
      assign sw_sel[g] = cur_q;
    end
  endgenerate

  wire cpu_src_tick = sw_tick[0];
  function automatic logic [6:0] speed_mask(input logic [2:0] spd);
    case (spd)
      cst_pkg::SPD_DIV8: speed_mask = 7'h07;
      cst_pkg::SPD_DIV4: speed_mask = 7'h03;
      cst_pkg::SPD_DIV2: speed_mask = 7'h01;
      cst_pkg::SPD_DIV1: speed_mask = 7'h00;
      cst_pkg::SPD_DIV16: speed_mask = 7'h0f;
      cst_pkg::SPD_DIV32: speed_mask = 7'h1f;
      cst_pkg::SPD_DIV128: speed_mask = 7'h7f;
      default: speed_mask = 7'h07; // reserved code falls back to divide by 8, same as the reset code
    endcase
  endfunction
  wire [6:0] cpu_mask = speed_mask(osc0_q[2:0]);
  // terminal count checked against the mask so a new setting lands on a boundary
  wire cpu_term = (cpu_cnt_q & cpu_mask) == cpu_mask;

  // usb clock: internal always halved, external halved unless bypassed
  wire usb_ext = cpu_usb_q[cst_pkg::USB_SEL_BIT];
  wire usb_src_tick = sw_tick[1];
  // the bypass follows the source in use, not the one just requested
  wire usb_nodiv = sw_sel[1] && cpu_usb_q[cst_pkg::USB_NODIV_BIT];

  // four-way source pick shared by the timer and clock output selects
  function automatic logic pick_src(input logic [1:0] sel, input logic fast, input logic ext,
                                    input logic slow, input logic alt);
    if (sel == cst_pkg::SRC_FAST) begin
      pick_src = fast;
    end else if (sel == cst_pkg::SRC_EXT) begin
      pick_src = ext;
    end else if (sel == cst_pkg::SRC_SLOW) begin
      pick_src = slow;
    end else begin
      pick_src = alt;
    end
  endfunction

  // capture timer source; the fourth code disables it
  wire tcap_tick = pick_src(tcap_sel_in, fast_tick, ext_tick, slow_tick, 1'b0);

  // interval timer source and 1..4 prescale
  wire itmr_src_tick = pick_src(itmr_sel_in, fast_tick, ext_tick, slow_tick, tcap_tick);
  wire itmr_term = itmr_cnt_q >= itmr_div_in;

  wire cpu_tick = cpu_src_tick && cpu_term;

  // clock output level; processor clock is shown as its enable pulse
  wire clock_output_pin_d = pick_src(clock_output_pin_sel_in, src_q[2], src_q[0], src_q[1], cpu_en_q);

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_cnt_q <= 7'h00;
      itmr_cnt_q <= 2'h0;
      usb_half_q <= 1'b0;
    end else begin
      if (cpu_src_tick) begin
        cpu_cnt_q <= cpu_term ? 7'h00 : cpu_cnt_q + 7'h01;
      end
      if (usb_src_tick) begin
        usb_half_q <= ~usb_half_q;
      end
      if (itmr_src_tick) begin
        itmr_cnt_q <= itmr_term ? 2'h0 : itmr_cnt_q + 2'h1;
      end
    end
  end

  // enables kept in their own flops so every output leaves a register
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_en_q <= 1'b0;
      usb_en_q <= 1'b0;
      itmr_en_q <= 1'b0;
      tcap_en_q <= 1'b0;
      clock_output_pin_q <= 1'b0;
    end else begin
      cpu_en_q <= cpu_tick;
      usb_en_q <= usb_src_tick && (usb_nodiv || usb_half_q);
      itmr_en_q <= itmr_src_tick && itmr_term;
      tcap_en_q <= tcap_tick;
      clock_output_pin_q <= clock_output_pin_d;
    end
  end

  // oscillator lock: enabled when fast osc feeds usb and not disabled
  logic lock_active_q;
  logic coarse_ok_q;
  wire lock_on = !usb_ext && !lock_q[cst_pkg::LOCK_DIS_BIT];
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_active_q <= 1'b0;
      coarse_ok_q <= 1'b0;
    end else begin
      lock_active_q <= lock_on && pkt_sync_q[1];
      coarse_ok_q <= lock_on && !lock_q[cst_pkg::FINE_ONLY_BIT];
    end
  end

  assign rdata_out = rdata_q;
  assign cpu_en_out = cpu_en_q;
  assign usb_en_out = usb_en_q;
  assign itmr_en_out = itmr_en_q;
  assign tcap_en_out = tcap_en_q;
  assign clock_output_pin_out = clock_output_pin_q;
  assign fast_trim_out = fast_trim_q;
  assign slow_trim_out = slow_trim_q;
  assign lowpwr_out = slow_trim_q[cst_pkg::LOWPWR_BIT];
  assign det_on_out = osc0_q[cst_pkg::DET_ON_BIT];
  assign sleep_timer_out = osc0_q[4:3];
  assign lock_active_out = lock_active_q;
  assign coarse_ok_out = coarse_ok_q;
endmodule

// >>> inc/cst_pkg.sv
package cst_pkg;
  // register offsets (documented I/O map)
  localparam logic [8:0] ADDR_CPU_USB_CFG = 9'h030;
  localparam logic [8:0] ADDR_FAST_TRIM = 9'h034;
  localparam logic [8:0] ADDR_SLOW_TRIM = 9'h036;
  localparam logic [8:0] ADDR_LOCK_CFG = 9'h039;
  localparam logic [8:0] ADDR_OSC_CTRL0 = 9'h1e0;
  // writable masks and reset values
  localparam logic [7:0] CPU_USB_CFG_MASK = 8'h61;
  localparam logic [7:0] SLOW_TRIM_MASK = 8'hbf;
  localparam logic [7:0] LOCK_CFG_MASK = 8'h03;
  localparam logic [7:0] OSC_CTRL0_MASK = 8'h3f;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // field positions
  localparam int CPU_SEL_BIT = 0;
  localparam int USB_SEL_BIT = 5;
  localparam int USB_NODIV_BIT = 6;
  localparam int LOWPWR_BIT = 7;
  localparam int DET_ON_BIT = 5;
  localparam int LOCK_DIS_BIT = 0;
  localparam int FINE_ONLY_BIT = 1;
  // processor speed codes
  localparam logic [2:0] SPD_DIV8 = 3'h0;
  localparam logic [2:0] SPD_DIV4 = 3'h1;
  localparam logic [2:0] SPD_DIV2 = 3'h2;
  localparam logic [2:0] SPD_DIV1 = 3'h3;
  localparam logic [2:0] SPD_DIV16 = 3'h4;
  localparam logic [2:0] SPD_DIV32 = 3'h5;
  localparam logic [2:0] SPD_DIV128 = 3'h6;
  // source selection codes for the timer / output muxes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_SLOW = 2'h2;
  localparam logic [1:0] SRC_ALT = 2'h3;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic extended_io_bank_flag;
  } cst_bus_t;

  typedef struct packed {
    logic fast_osc;
    logic slow_osc;
    logic ext_clk;
  } cst_src_t;
endpackage

// >>> tb/clock_select_and_trim_tb_top.sv
`timescale 1ns/1ns
module clock_select_and_trim_tb_top;
  logic clk_in = 0, rst_n_in = 0, sleep_in = 0, usb_packet_in = 0, oprev = 0;
  logic fo = 0, so = 0, eo = 0;
  cst_pkg::cst_bus_t bus_in = '0;
  wire cst_pkg::cst_src_t src_in = '{fo, so, eo};
  logic [1:0] isel = 0, idiv = 0, tsel = 0, osel = 0, sleep_timer_out;
  logic [7:0] rdata_out, fast_trim_out, slow_trim_out;
  logic cpu_en_out, usb_en_out, itmr_en_out, tcap_en_out, clock_output_pin_out;
  logic lowpwr_out, det_on_out, lock_active_out, coarse_ok_out;
  int num_errors = 0, checks_done = 0;
  // sources run at 8, 12 and 20 clocks, slow enough for edge detection
  wire [4:0] ev = {clock_output_pin_out & ~oprev, tcap_en_out, itmr_en_out, usb_en_out, cpu_en_out};
  // cfg, speed, isel, idiv, tsel, osel, then periods: cpu, usb, itmr, tcap, clock_output_pin
  int rw[8][11] = '{'{0,0,0,0,0,0,64,16,8,8,8}, '{64,1,1,1,1,1,32,16,24,12,12},
    '{33,3,2,2,2,2,12,24,60,20,20}, '{97,2,3,3,0,3,24,12,32,8,24},
    '{0,4,0,0,3,0,128,16,8,0,8}, '{0,5,0,0,0,0,256,16,8,8,8},
    '{0,6,0,0,0,0,1024,16,8,8,8}, '{0,7,0,0,0,0,64,16,8,8,8}};
  // addr, write bank, wdata, read bank, readback
  logic [8:0] rg[9][5] = '{'{9'h030,0,9'h0ff,0,9'h061}, '{9'h030,1,0,0,9'h061},
    '{9'h030,0,9'h0ff,1,0}, '{9'h1e0,1,9'h0ff,1,9'h03f}, '{9'h1e0,0,0,1,9'h03f},
    '{9'h039,0,9'h0ff,0,9'h003}, '{9'h036,0,9'h0ff,0,9'h0bf},
    '{9'h034,0,9'h0a5,0,9'h0a5}, '{9'h035,0,9'h0ff,0,0}};
  logic [7:0] lk[4][4] = '{'{0,0,1,1}, '{0,2,1,0}, '{0,1,0,0}, '{32,0,0,0}};
  always #25 clk_in = ~clk_in;
  always #200 fo = ~fo;
  always #300 eo = ~eo;
  always #500 so = ~so;
  always @(posedge clk_in) oprev <= clock_output_pin_out;
  cst_clock_select dut_u (.clk_in, .rst_n_in, .bus_in, .src_in, .itmr_sel_in(isel),
    .itmr_div_in(idiv), .tcap_sel_in(tsel), .clock_output_pin_sel_in(osel), .sleep_in, .usb_packet_in,
    .rdata_out, .cpu_en_out, .usb_en_out, .itmr_en_out, .tcap_en_out, .clock_output_pin_out,
    .fast_trim_out, .slow_trim_out, .lowpwr_out, .det_on_out, .sleep_timer_out,
    .lock_active_out, .coarse_ok_out);
  task chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %0h got %0h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task acc(input logic [8:0] a, input logic x, w, input logic [7:0] d);
    @(negedge clk_in);
    bus_in = '{a, d, w, !w, x};
    @(negedge clk_in);
    bus_in.wr = 0;
    bus_in.rd = 0;
    @(negedge clk_in);
  endtask
  // the first interval may still straddle a divider change, so the third is kept
  task meas(input int k, e);
    int n;
    for (int r = 0; r < 3; r++) begin
      n = 0;
      do begin
        @(negedge clk_in);
        n++;
      end while (!ev[k] && n < 2500);
      if (n == 2500) break;
    end
    chk("period", n == 2500 ? 0 : n, e);
    if (n == 2500 && e != 0) close_out;
  endtask
  initial begin
    repeat (3) @(negedge clk_in);
    rst_n_in = 1;
    repeat (3) @(negedge clk_in);
    foreach (rw[i]) begin
      acc(9'h030, 1'b0, 1'b1, 8'(rw[i][0]));
      acc(9'h1e0, 1'b1, 1'b1, 8'(rw[i][1]));
      {isel, idiv, tsel, osel} = {2'(rw[i][2]), 2'(rw[i][3]), 2'(rw[i][4]), 2'(rw[i][5])};
      for (int k = 0; k < 5; k++) meas(k, rw[i][6+k]);
    end
    foreach (rg[i]) begin
      acc(rg[i][0], rg[i][1][0], 1'b1, rg[i][2][7:0]);
      acc(rg[i][0], rg[i][3][0], 1'b0, 8'h00);
      chk("reg", rdata_out, rg[i][4]);
    end
    chk("det_sleep", {det_on_out, sleep_timer_out}, 3'h7);
    // clear low power by read-modify-write, bias never set to 10b
    acc(9'h036, 1'b0, 1'b0, 8'h00);
    acc(9'h036, 1'b0, 1'b1, rdata_out & 8'h7f);
    chk("lowpwr", lowpwr_out, 1'b0);
    acc(9'h036, 1'b0, 1'b0, 8'h00);
    chk("slow_keep", rdata_out, 8'h3f);
    usb_packet_in = 1;
    foreach (lk[i]) begin
      acc(9'h030, 1'b0, 1'b1, lk[i][0]);
      acc(9'h039, 1'b0, 1'b1, lk[i][1]);
      repeat (3) @(negedge clk_in);
      chk("lock", lock_active_out, lk[i][2]);
      if (lk[i][2]) chk("coarse", coarse_ok_out, lk[i][3]);
    end
    acc(9'h030, 1'b0, 1'b1, 8'h01);
    sleep_in = 1;
    repeat (2) @(negedge clk_in);
    sleep_in = 0;
    acc(9'h030, 1'b0, 1'b0, 8'h00);
    chk("sleep", rdata_out, 8'h00);
    rst_n_in = 0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1;
    repeat (3) @(negedge clk_in);
    acc(9'h1e0, 1'b1, 1'b0, 8'h00);
    chk("rst_speed", rdata_out, 8'h00);
    acc(9'h039, 1'b0, 1'b0, 8'h00);
    chk("rst_lock", rdata_out, 8'h00);
    close_out;
  end
endmodule

// >>> tb/cst_clock_select_assertions.sv
`timescale 1ns/1ns
module cst_clock_select_assertions (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire cst_pkg::cst_bus_t bus_in,
  input wire logic usb_packet_in,
  input wire logic [7:0] rdata_out,
  input wire logic cpu_en_out,
  input wire logic [7:0] fast_trim_out,
  input wire logic [7:0] slow_trim_out,
  input wire logic lowpwr_out,
  input wire logic det_on_out,
  input wire logic [1:0] sleep_timer_out,
  input wire logic lock_active_out,
  input wire logic coarse_ok_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic dis_q;
  logic fine_q;
  wire wr0 = bus_in.wr & !bus_in.extended_io_bank_flag;
  wire rd0 = bus_in.rd & !bus_in.extended_io_bank_flag;
  wire wr_osc = bus_in.wr & (bus_in.addr == 9'h1e0);
  // shadow of the lock config, refreshed by the same writes the design takes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dis_q <= 1'b0;
      fine_q <= 1'b0;
    end else if (wr0 && bus_in.addr == 9'h039) begin
      dis_q <= bus_in.wdata[0];
      fine_q <= bus_in.wdata[1];
    end
  end
  chk_fast_trim_load: assert property (wr0 && bus_in.addr == 9'h034
    |=> fast_trim_out == $past(bus_in.wdata)) else $error("fast trim not loaded");
  chk_slow_trim_load: assert property (wr0 && bus_in.addr == 9'h036
    |=> slow_trim_out[5:0] == $past(bus_in.wdata[5:0]) && lowpwr_out == $past(bus_in.wdata[7]))
    else $error("slow trim not loaded");
  chk_sleep_ctrl_load: assert property (wr_osc && bus_in.extended_io_bank_flag
    |=> det_on_out == $past(bus_in.wdata[5]) && sleep_timer_out == $past(bus_in.wdata[4:3]))
    else $error("osc control not loaded");
  chk_xio_write_refused: assert property (wr_osc && !bus_in.extended_io_bank_flag
    |=> $stable(det_on_out) && $stable(sleep_timer_out)) else $error("osc control wrong bank");
  chk_reserved_read_zero: assert property (rd0 && bus_in.addr == 9'h030
    |=> (rdata_out & 8'h9e) == 8'h00) else $error("reserved bits not zero");
  chk_wrong_bank_read: assert property (bus_in.rd && bus_in.extended_io_bank_flag && bus_in.addr == 9'h030
    |=> rdata_out == 8'h00) else $error("wrong bank read not zero");
  chk_lock_disabled: assert property (dis_q && $past(dis_q) |-> !lock_active_out)
    else $error("lock active while disabled");
  chk_fine_only_gate: assert property (fine_q && $past(fine_q) |-> !coarse_ok_out)
    else $error("coarse allowed in fine only");
  chk_cpu_pulse_single: assert property (cpu_en_out |=> !cpu_en_out)
    else $error("cpu enable longer than a cycle");
  cover property (lock_active_out && usb_packet_in);
  cover property (dis_q && usb_packet_in);
  cover property (bus_in.rd && bus_in.extended_io_bank_flag);
endmodule
bind cst_clock_select cst_clock_select_assertions u_chk (.clk_in, .rst_n_in, .bus_in,
  .usb_packet_in, .rdata_out, .cpu_en_out, .fast_trim_out, .slow_trim_out, .lowpwr_out,
  .det_on_out, .sleep_timer_out, .lock_active_out, .coarse_ok_out);
